// >>> mmx_pkg.sv
`default_nettype none
package mmx_pkg;
   localparam int unsigned CLK_PERIOD_NS = 5;
   // Internal RAM transfer on enable-clock sync: two cycles
   localparam int unsigned RAM_SYNC_CYCLES = 2;
   localparam logic [2:0] FNC_S8 = 3'h0;
   localparam logic [2:0] FNC_S16 = 3'h1;
   localparam logic [2:0] FNC_U8 = 3'h4;
   localparam logic [2:0] FNC_U16 = 3'h5;
   localparam logic [31:0] READ_STEP = 32'h2;
   localparam logic [31:0] WRITE_STEP = 32'h2;
   localparam logic [31:0] WRITE_OFS_WORD = 32'h2;
   localparam logic [31:0] WRITE_OFS_LONG = 32'h6;
   localparam logic [2:0] BYTES_WORD = 3'h2;
   localparam logic [2:0] BYTES_LONG = 3'h4;
   localparam logic [1:0] SZ_BYTE = 2'h0;
   localparam logic [1:0] SZ_WORD = 2'h1;
   localparam logic [1:0] SZ_LONG = 2'h2;

   typedef enum logic [3:0] {
      MMX_OP_GENERAL_MOVE,
      MMX_OP_QUICK_MOVE,
      MMX_OP_REGISTER_MOVE,
      MMX_OP_REGISTER_QUICK_MOVE,
      MMX_OP_SIGN_EXTEND_MOVE,
      MMX_OP_PERIPHERAL_READ,
      MMX_OP_PERIPHERAL_READ_ECLK,
      MMX_OP_PERIPHERAL_WRITE,
      MMX_OP_PERIPHERAL_WRITE_ECLK,
      MMX_OP_SIGNED_MULTIPLY,
      MMX_OP_UNSIGNED_MULTIPLY
   } mmx_op_t;

   typedef struct packed {
      mmx_op_t op;
      logic [1:0] size_field;
      logic [2:0] multiply_function_code;
      logic [31:0] src_data;
      logic [31:0] dst_data;
      logic [31:0] target_address;
      logic [7:0] imm8;
      logic [3:0] src_reg;
      logic [3:0] dst_reg;
      logic src_internal_ram;
   } mmx_cmd_t;

   typedef struct packed {
      logic wr;
      logic [31:0] addr;
      logic [7:0] wdata;
      logic eclk_sync;
      logic internal_ram;
   } mmx_bus_t;

   typedef struct packed {
      logic [31:0] data;
      logic [3:0] reg_sel;
      logic to_reg;
      logic bad_size;
   } mmx_res_t;
endpackage : mmx_pkg
`default_nettype wire

// >>> mmx_exec.sv
`default_nettype none
module mmx_exec (
   input wire logic clk_in,                       // System clock
   input wire logic rst_n_in,                     // Async reset, active low
   input wire logic eclk_in,                      // Peripheral enable clock pin
   input wire logic cmd_valid_in,                 // Command offered
   output logic cmd_ready_out,                    // Idle, command accepted
   input wire mmx_pkg::mmx_cmd_t cmd_in,          // Command fields
   output logic bus_req_out,                      // Byte access request
   output mmx_pkg::mmx_bus_t bus_out,             // Byte access fields
   input wire logic bus_ack_in,                   // Byte access done
   input wire logic [7:0] bus_rdata_in,           // Read byte
   output logic res_valid_out,                    // Result pulse
   output mmx_pkg::mmx_res_t res_out              // Result fields
);
   import mmx_pkg::*;

   typedef enum logic [2:0] {ST_IDLE, ST_WAIT_E, ST_ACCESS, ST_RAM, ST_DONE} mmx_state_t;

   typedef struct packed {
      mmx_state_t st;
      mmx_cmd_t cmd;
      logic [31:0] addr;
      logic [31:0] acc;
      logic [2:0] left;
      logic [1:0] ram_cnt;
      logic [2:0] e_sync;
      logic e_stable;
      logic e_prev_fall;
      logic wr;
      logic eclk;
      logic req;
      mmx_bus_t bus;
      logic rv;
      mmx_res_t res;
   } mmx_state_s_t;

   mmx_state_s_t s_reg, s_next;

   function automatic logic [31:0] sext(input logic [31:0] v, input logic [1:0] sz);
      case (sz)
         SZ_BYTE: sext = {{24{v[7]}}, v[7:0]};
         SZ_WORD: sext = {{16{v[15]}}, v[15:0]};
         default: sext = v;
      endcase
   endfunction : sext

   function automatic logic [31:0] trunc(input logic [31:0] v, input logic [1:0] sz);
      case (sz)
         SZ_BYTE: trunc = {24'h0, v[7:0]};
         SZ_WORD: trunc = {16'h0, v[15:0]};
         default: trunc = v;
      endcase
   endfunction : trunc

   // Byte count for a peripheral op from size field
   function automatic logic [2:0] nbytes(input logic [1:0] sz);
      nbytes = (sz == SZ_LONG || sz == 2'h3) ? BYTES_LONG : BYTES_WORD;
   endfunction : nbytes

   logic e_fall;
   logic [15:0] prod_s8;
   logic [31:0] prod_s16;
   logic [15:0] prod_u8;
   logic [31:0] prod_u16;

   // Fall counts only once both late stages read low
   assign e_fall = s_reg.e_stable && !s_reg.e_sync[2] && !s_reg.e_sync[1];
   assign prod_s8 = 16'($signed(cmd_in.dst_data[7:0]) * $signed(cmd_in.src_data[7:0]));
   assign prod_s16 = 32'($signed(cmd_in.dst_data[15:0]) * $signed(cmd_in.src_data[15:0]));
   assign prod_u8 = 16'(cmd_in.dst_data[7:0] * cmd_in.src_data[7:0]);
   assign prod_u16 = 32'(cmd_in.dst_data[15:0] * cmd_in.src_data[15:0]);

   always_comb begin
      logic [2:0] n;
      logic sz_long;
      n = 3'h0;
      sz_long = 1'b0;
      s_next = s_reg;
      s_next.rv = 1'b0;
      s_next.e_sync = {s_reg.e_sync[1:0], eclk_in};
      // Change counts once second and third stages agree
      if (s_reg.e_sync[2] == s_reg.e_sync[1]) begin
         s_next.e_stable = s_reg.e_sync[1];
      end
      s_next.e_prev_fall = e_fall;
      case (s_reg.st)
         ST_IDLE: begin
            if (cmd_valid_in) begin
               s_next.cmd = cmd_in;
               s_next.res.bad_size = 1'b0;
               s_next.res.to_reg = 1'b0;
               s_next.res.reg_sel = cmd_in.dst_reg;
               s_next.acc = 32'h0;
               sz_long = cmd_in.size_field[0];
               n = nbytes(cmd_in.size_field);
               s_next.st = ST_DONE;
               case (cmd_in.op)
                  MMX_OP_GENERAL_MOVE: begin
                     s_next.res.data = trunc(cmd_in.src_data, cmd_in.size_field);
                  end
                  MMX_OP_QUICK_MOVE: begin
                     s_next.res.data = trunc(sext({24'h0, cmd_in.imm8}, SZ_BYTE),
                        cmd_in.size_field);
                  end
                  MMX_OP_REGISTER_MOVE: begin
                     s_next.res.data = trunc(cmd_in.src_data, cmd_in.size_field);
                     s_next.res.to_reg = 1'b1;
                  end
                  MMX_OP_REGISTER_QUICK_MOVE: begin
                     s_next.res.data = trunc({{28{cmd_in.imm8[3]}}, cmd_in.imm8[3:0]},
                        cmd_in.size_field);
                     s_next.res.to_reg = 1'b1;
                  end
                  MMX_OP_SIGN_EXTEND_MOVE: begin
                     s_next.res.data = sext(cmd_in.src_data, cmd_in.size_field);
                  end
                  MMX_OP_SIGNED_MULTIPLY: begin
                     case (cmd_in.multiply_function_code)
                        FNC_S8: s_next.res.data = {16'h0, prod_s8};
                        FNC_S16: s_next.res.data = prod_s16;
                        default: begin
                           s_next.res.data = 32'h0;
                           s_next.res.bad_size = 1'b1;
                        end
                     endcase
                  end
                  MMX_OP_UNSIGNED_MULTIPLY: begin
                     case (cmd_in.multiply_function_code)
                        FNC_U8: s_next.res.data = {16'h0, prod_u8};
                        FNC_U16: s_next.res.data = prod_u16;
                        default: begin
                           s_next.res.data = 32'h0;
                           s_next.res.bad_size = 1'b1;
                        end
                     endcase
                  end
                  MMX_OP_PERIPHERAL_READ, MMX_OP_PERIPHERAL_READ_ECLK: begin
                     s_next.wr = 1'b0;
                     s_next.eclk = (cmd_in.op == MMX_OP_PERIPHERAL_READ_ECLK);
                     s_next.addr = cmd_in.target_address;
                     // Bus-timed form takes one size bit
                     if (cmd_in.op == MMX_OP_PERIPHERAL_READ) begin
                        n = sz_long ? BYTES_LONG : BYTES_WORD;
                     end
                     s_next.left = n;
                     s_next.st = s_next.eclk ? ST_WAIT_E : ST_ACCESS;
                  end
                  MMX_OP_PERIPHERAL_WRITE, MMX_OP_PERIPHERAL_WRITE_ECLK: begin
                     s_next.wr = 1'b1;
                     s_next.eclk = (cmd_in.op == MMX_OP_PERIPHERAL_WRITE_ECLK);
                     if (cmd_in.op == MMX_OP_PERIPHERAL_WRITE) begin
                        n = sz_long ? BYTES_LONG : BYTES_WORD;
                     end
                     // Lowest byte goes to the highest address
                     s_next.addr = cmd_in.target_address +
                        ((n == BYTES_LONG) ? WRITE_OFS_LONG : WRITE_OFS_WORD);
                     s_next.acc = cmd_in.src_data;
                     s_next.left = n;
                     s_next.st = s_next.eclk ? ST_WAIT_E : ST_ACCESS;
                  end
                  default: begin
                     s_next.res.data = 32'h0;
                     s_next.res.bad_size = 1'b1;
                  end
               endcase
            end
         end
         ST_WAIT_E: begin
            if (e_fall && !s_reg.e_prev_fall) begin
               s_next.st = s_reg.cmd.src_internal_ram ? ST_RAM : ST_ACCESS;
               s_next.ram_cnt = 2'(RAM_SYNC_CYCLES - 1);
            end
         end
         ST_RAM, ST_ACCESS: begin
            s_next.req = 1'b1;
            s_next.bus.wr = s_reg.wr;
            s_next.bus.addr = s_reg.addr;
            s_next.bus.wdata = s_reg.acc[7:0];
            s_next.bus.eclk_sync = s_reg.eclk;
            s_next.bus.internal_ram = (s_reg.st == ST_RAM);
            // RAM cycle counts only while the request stands
            if (s_reg.st == ST_RAM && s_reg.req && s_reg.ram_cnt != 2'h0) begin
               s_next.ram_cnt = s_reg.ram_cnt - 2'h1;
            end
            if (s_reg.req && bus_ack_in ||
                  s_reg.st == ST_RAM && s_reg.req && s_reg.ram_cnt == 2'h0) begin
               s_next.req = 1'b0;
               s_next.left = s_reg.left - 3'h1;
               if (s_reg.wr) begin
                  s_next.acc = {8'h0, s_reg.acc[31:8]};
                  s_next.addr = s_reg.addr - WRITE_STEP;
               end else begin
                  // Earlier bytes are more significant
                  s_next.acc = {s_reg.acc[23:0], bus_rdata_in};
                  s_next.addr = s_reg.addr + READ_STEP;
               end
               if (s_reg.left == 3'h1) begin
                  s_next.st = ST_DONE;
                  s_next.res.data = s_reg.wr ? 32'h0 : {s_reg.acc[23:0], bus_rdata_in};
               end else begin
                  s_next.st = s_reg.eclk ? ST_WAIT_E : ST_ACCESS;
               end
            end
         end
         ST_DONE: begin
            s_next.rv = 1'b1;
            s_next.st = ST_IDLE;
         end
         default: s_next.st = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign cmd_ready_out = (s_reg.st == ST_IDLE);
   assign bus_req_out = s_reg.req;
   assign bus_out = s_reg.bus;
   assign res_valid_out = s_reg.rv;
   assign res_out = s_reg.res;

   logic cmd_take;
   assign cmd_take = cmd_ready_out && cmd_valid_in;

   // Result checks
   a_gmove_long: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      cmd_take && cmd_in.op == MMX_OP_GENERAL_MOVE && cmd_in.size_field == SZ_LONG |=>
      s_reg.res.data == $past(cmd_in.src_data)) else $error("general move long wrong");
   a_gmove_byte: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      cmd_take && cmd_in.op == MMX_OP_GENERAL_MOVE && cmd_in.size_field == SZ_BYTE |=>
      s_reg.res.data == {24'h0, s_reg.cmd.src_data[7:0]}) else $error("general move byte wrong");
   a_quick_long: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      cmd_take && cmd_in.op == MMX_OP_QUICK_MOVE && cmd_in.size_field == SZ_LONG |=>
      s_reg.res.data == {{24{s_reg.cmd.imm8[7]}}, s_reg.cmd.imm8}) else $error("quick long");
   a_quick_word: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      cmd_take && cmd_in.op == MMX_OP_QUICK_MOVE && cmd_in.size_field == SZ_WORD |=>
      s_reg.res.data == {16'h0, {8{s_reg.cmd.imm8[7]}}, s_reg.cmd.imm8}) else $error("quick word");
   a_rmove_dest: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      cmd_take && cmd_in.op == MMX_OP_REGISTER_MOVE |=>
      s_reg.res.to_reg && s_reg.res.reg_sel == $past(cmd_in.dst_reg)) else $error("reg move dest");
   a_rquick_sext: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      cmd_take && cmd_in.op == MMX_OP_REGISTER_QUICK_MOVE && cmd_in.size_field == SZ_LONG |=>
      s_reg.res.data == {{28{s_reg.cmd.imm8[3]}}, s_reg.cmd.imm8[3:0]}) else $error("rq move");
   a_sext_word: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      cmd_take && cmd_in.op == MMX_OP_SIGN_EXTEND_MOVE && cmd_in.size_field == SZ_WORD |=>
      s_reg.res.data[31:16] == {16{s_reg.cmd.src_data[15]}}) else $error("sext word");
   a_smul_byte: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      cmd_take && cmd_in.op == MMX_OP_SIGNED_MULTIPLY && cmd_in.multiply_function_code == FNC_S8
      |=> s_reg.res.data[31:16] == 16'h0 && !s_reg.res.bad_size) else $error("smul byte");
   a_smul_word: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      cmd_take && cmd_in.op == MMX_OP_SIGNED_MULTIPLY && cmd_in.multiply_function_code == FNC_S16
      |=> s_reg.res.data == 32'($signed(s_reg.cmd.dst_data[15:0]) *
      $signed(s_reg.cmd.src_data[15:0]))) else $error("smul word");
   a_smul_bad: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      cmd_take && cmd_in.op == MMX_OP_SIGNED_MULTIPLY && cmd_in.multiply_function_code != FNC_S8
      && cmd_in.multiply_function_code != FNC_S16 |=> s_reg.res.bad_size) else $error("smul bad");
   a_umul_byte: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      cmd_take && cmd_in.op == MMX_OP_UNSIGNED_MULTIPLY && cmd_in.multiply_function_code == FNC_U8
      |=> s_reg.res.data == {16'h0, 16'(s_reg.cmd.dst_data[7:0] * s_reg.cmd.src_data[7:0])})
      else $error("umul byte");
   a_umul_bad: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      cmd_take && cmd_in.op == MMX_OP_UNSIGNED_MULTIPLY && cmd_in.multiply_function_code != FNC_U8
      && cmd_in.multiply_function_code != FNC_U16 |=> s_reg.res.bad_size) else $error("umul bad");

   // Transfer setup checks
   a_read_first: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      cmd_take && (cmd_in.op == MMX_OP_PERIPHERAL_READ || cmd_in.op == MMX_OP_PERIPHERAL_READ_ECLK)
      |=> s_reg.addr == $past(cmd_in.target_address)) else $error("read start address");
   a_read_long: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      cmd_take && cmd_in.op == MMX_OP_PERIPHERAL_READ && cmd_in.size_field[0] |=>
      s_reg.left == BYTES_LONG) else $error("read long count");
   a_read_word: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      cmd_take && cmd_in.op == MMX_OP_PERIPHERAL_READ && !cmd_in.size_field[0] |=>
      s_reg.left == BYTES_WORD) else $error("read word count");
   a_write_word: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      cmd_take && cmd_in.op == MMX_OP_PERIPHERAL_WRITE && !cmd_in.size_field[0] |=>
      s_reg.addr == $past(cmd_in.target_address) + WRITE_OFS_WORD) else $error("write word start");
   a_write_long: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      cmd_take && cmd_in.op == MMX_OP_PERIPHERAL_WRITE && cmd_in.size_field[0] |=>
      s_reg.addr == $past(cmd_in.target_address) + WRITE_OFS_LONG) else $error("write long start");
   a_write_data: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      cmd_take && cmd_in.op == MMX_OP_PERIPHERAL_WRITE |=>
      s_reg.acc == $past(cmd_in.src_data)) else $error("write data load");

   // Bus and result pulse behaviour checks
   a_eclk_start: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      s_reg.st == ST_WAIT_E && e_fall && !s_reg.e_prev_fall |=>
      s_reg.st == ST_ACCESS || s_reg.st == ST_RAM) else $error("eclk start missed");
   a_ram_req_len: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      $rose(bus_req_out && bus_out.internal_ram) |=> bus_req_out ##1 !bus_req_out)
      else $error("RAM cycle length");
   a_req_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      bus_req_out && !bus_ack_in && !bus_out.internal_ram |=> bus_req_out && $stable(bus_out))
      else $error("request dropped early");
   a_res_pulse: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      res_valid_out |=> !res_valid_out) else $error("result pulse too long");
   a_res_idle: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      res_valid_out |-> cmd_ready_out) else $error("result while busy");

   a_read_step_up: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      s_reg.req && bus_ack_in && !s_reg.wr && s_reg.left > 3'h1 |=>
      s_reg.addr == $past(s_reg.addr) + 32'h2);
   a_read_parity: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      s_reg.req && !s_reg.wr |-> s_reg.bus.addr[0] == s_reg.cmd.target_address[0]);
   a_write_parity: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      s_reg.req && s_reg.wr |-> s_reg.bus.addr[0] == s_reg.cmd.target_address[0]);
   a_write_step_down: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      s_reg.req && bus_ack_in && s_reg.wr && s_reg.left > 3'h1 |=>
      s_reg.addr == $past(s_reg.addr) - 32'h2);
   a_ram_two_cycles: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      $rose(s_reg.st == ST_RAM) |-> ##[1:3] s_reg.st != ST_RAM);
   a_eclk_wait_fall: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      s_reg.st == ST_WAIT_E && !e_fall |=> s_reg.st == ST_WAIT_E);
   a_sext_full: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      cmd_ready_out && cmd_valid_in && cmd_in.op == MMX_OP_SIGN_EXTEND_MOVE &&
      cmd_in.size_field == 2'h0 |=> s_reg.res.data[31:8] == {24{s_reg.cmd.src_data[7]}});
   a_umul_word: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      cmd_ready_out && cmd_valid_in && cmd_in.op == MMX_OP_UNSIGNED_MULTIPLY &&
      cmd_in.multiply_function_code == 3'h5 |=> ##1 res_valid_out &&
      res_out.data == s_reg.cmd.dst_data[15:0] * s_reg.cmd.src_data[15:0]);
endmodule : mmx_exec
`default_nettype wire

// >>> mmx_periph.sv
`default_nettype none
module mmx_periph (
   input wire logic clk_in,               // System clock
   input wire logic rst_n_in,             // Async reset, active low
   input wire logic slow_in,              // Delay each ack by four cycles
   input wire logic bus_req_in,           // Byte access request
   input wire mmx_pkg::mmx_bus_t bus_in,  // Byte access fields
   output logic bus_ack_out,              // Byte done pulse
   output logic [7:0] rdata_out           // Read byte
);
   timeunit 1ns;
   timeprecision 1ps;
   import mmx_pkg::*;
   logic [2:0] cnt_reg;
   logic [7:0] junk_reg;
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt_reg <= 3'h0;
         bus_ack_out <= 1'b0;
         junk_reg <= 8'h00;
      end else begin
         junk_reg <= junk_reg + 8'h3B;
         bus_ack_out <= 1'b0;
         // Internal RAM cycles finish on their own
         if (bus_req_in && !bus_ack_out && !bus_in.internal_ram) begin
            if (cnt_reg == (slow_in ? 3'h4 : 3'h0)) begin
               bus_ack_out <= 1'b1;
               cnt_reg <= 3'h0;
            end else begin
               cnt_reg <= cnt_reg + 3'h1;
            end
         end
      end
   end
   // Undriven bus shows a moving pattern
   assign rdata_out = (bus_req_in && (bus_ack_out || bus_in.internal_ram)) ?
      (bus_in.addr[7:0] ^ 8'h5A) : junk_reg;
endmodule : mmx_periph
`default_nettype wire

// >>> mmx_exec_tb.sv
`default_nettype none
module mmx_exec_tb import mmx_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_in = 0, eclk_in = 0, rst_n_in = 0, cmd_valid_in = 0, slow = 0;
   logic cmd_ready_out, bus_req_out, bus_ack_in, res_valid_out, req_q = 0, ack_q = 0;
   logic [7:0] bus_rdata_in;
   mmx_cmd_t cmd_in = '0;
   mmx_bus_t bus_out;
   mmx_res_t res_out;
   logic [31:0] aq[$], wq[$], eq[$], rq[$];
   int err_total = 0, compares = 0, cycles = 0, run = 0;
   always #2.5 clk_in = ~clk_in;
   always #40 eclk_in = ~eclk_in;
   mmx_exec DUT (.clk_in(clk_in), .rst_n_in(rst_n_in), .eclk_in(eclk_in),
      .cmd_valid_in(cmd_valid_in), .cmd_ready_out(cmd_ready_out), .cmd_in(cmd_in),
      .bus_req_out(bus_req_out), .bus_out(bus_out), .bus_ack_in(bus_ack_in),
      .bus_rdata_in(bus_rdata_in), .res_valid_out(res_valid_out), .res_out(res_out));
   mmx_periph PERIPH (.clk_in(clk_in), .rst_n_in(rst_n_in), .slow_in(slow),
      .bus_req_in(bus_req_out), .bus_in(bus_out), .bus_ack_out(bus_ack_in),
      .rdata_out(bus_rdata_in));
   // Log each byte access as it starts
   always @(posedge clk_in) begin
      cycles++;
      if (bus_req_out && (!req_q || ack_q)) begin
         aq.push_back(bus_out.addr);
         wq.push_back({24'h0, bus_out.wdata});
         eq.push_back({31'h0, eclk_in});
      end
      if (bus_req_out) run++;
      else if (req_q) begin
         rq.push_back(32'(run));
         run = 0;
      end
      req_q = bus_req_out;
      ack_q = bus_ack_in;
      if (cycles == 50000) begin
         err_total++;
         complete_run();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask : check
   function automatic mmx_cmd_t mk(input mmx_op_t op, input logic [1:0] sz,
         input logic [31:0] src);
      mmx_cmd_t c;
      c = '0;
      c.op = op;
      c.size_field = sz;
      c.src_data = src;
      return c;
   endfunction : mk
   task automatic run_cmd(input mmx_cmd_t c);
      int n;
      aq.delete(); wq.delete(); eq.delete(); rq.delete();
      @(posedge clk_in);
      cmd_in <= c;
      cmd_valid_in <= 1'b1;
      do @(posedge clk_in); while (cmd_ready_out !== 1'b1);
      cmd_valid_in <= 1'b0;
      n = 0;
      while (res_valid_out !== 1'b1 && n < 2000) begin
         @(posedge clk_in);
         n++;
      end
      check({31'h0, res_valid_out}, 32'h1);
   endtask : run_cmd
   task automatic t_move();
      mmx_cmd_t c;
      logic [31:0] m;
      for (int s = 0; s < 3; s++) begin
         m = (s == 0) ? 32'hFF : (s == 1) ? 32'hFFFF : 32'hFFFF_FFFF;
         run_cmd(mk(MMX_OP_GENERAL_MOVE, 2'(s), 32'h89AB_CDEF));
         check(res_out.data & m, 32'h89AB_CDEF & m);
      end
      c = mk(MMX_OP_QUICK_MOVE, SZ_LONG, 32'h0);
      c.imm8 = 8'h80;
      run_cmd(c);
      check(res_out.data, 32'hFFFF_FF80);
      c.imm8 = 8'h7F;
      c.size_field = SZ_WORD;
      run_cmd(c);
      check(res_out.data & 32'hFFFF, 32'h007F);
      c = mk(MMX_OP_REGISTER_MOVE, SZ_LONG, 32'h1234_5678);
      c.src_reg = 4'hF;
      c.dst_reg = 4'hE;
      run_cmd(c);
      check(res_out.data, 32'h1234_5678);
      check({27'h0, res_out.to_reg, res_out.reg_sel}, 32'h1E);
      c = mk(MMX_OP_REGISTER_QUICK_MOVE, SZ_LONG, 32'h0);
      c.imm8 = 8'h08;
      c.dst_reg = 4'hF;
      run_cmd(c);
      check(res_out.data, 32'hFFFF_FFF8);
      c.imm8 = 8'h07;
      run_cmd(c);
      check(res_out.data, 32'h0000_0007);
      run_cmd(mk(MMX_OP_SIGN_EXTEND_MOVE, SZ_BYTE, 32'h0000_0080));
      check(res_out.data, 32'hFFFF_FF80);
      run_cmd(mk(MMX_OP_SIGN_EXTEND_MOVE, SZ_WORD, 32'h0000_8001));
      check(res_out.data, 32'hFFFF_8001);
   endtask : t_move
   task automatic mul(input mmx_op_t op, input logic [2:0] f, input logic [31:0] s,
         input logic [31:0] d, input logic [31:0] m, input logic [31:0] e);
      mmx_cmd_t c;
      c = mk(op, SZ_WORD, s);
      c.multiply_function_code = f;
      c.dst_data = d;
      run_cmd(c);
      check(res_out.data & m, e);
   endtask : mul
   task automatic t_mul();
      mul(MMX_OP_SIGNED_MULTIPLY, FNC_S8, 32'hFE, 32'h03, 32'hFFFF, 32'hFFFA);
      mul(MMX_OP_SIGNED_MULTIPLY, FNC_S16, 32'h8000, 32'h2, 32'hFFFF_FFFF, 32'hFFFF_0000);
      mul(MMX_OP_UNSIGNED_MULTIPLY, FNC_U8, 32'hFF, 32'hFF, 32'hFFFF, 32'hFE01);
      mul(MMX_OP_UNSIGNED_MULTIPLY, FNC_U16, 32'hFFFF, 32'hFFFF, 32'hFFFF_FFFF, 32'hFFFE_0001);
      mul(MMX_OP_SIGNED_MULTIPLY, 3'h2, 32'h5, 32'h5, 32'hFFFF_FFFF, 32'h0);
      check({31'h0, res_out.bad_size}, 32'h1);
   endtask : t_mul
   task automatic do_read(input mmx_op_t op, input logic [31:0] ta, input logic [1:0] sz,
         input int n, input logic ram, input logic ek);
      mmx_cmd_t c;
      logic [31:0] e;
      c = mk(op, sz, 32'h0);
      c.target_address = ta;
      c.src_internal_ram = ram;
      run_cmd(c);
      check(32'(aq.size()), 32'(n));
      e = 32'h0;
      for (int i = 0; i < n; i++) begin
         check(aq[i], ta + 32'(2 * i));
         e = {e[23:0], 8'(ta + 32'(2 * i)) ^ 8'h5A};
         if (ek) check(eq[i], 32'h0);
         if (ram) check(rq[i], 32'(RAM_SYNC_CYCLES));
      end
      check(res_out.data & ((n == 4) ? 32'hFFFF_FFFF : 32'hFFFF), e);
      check({31'h0, bus_out.eclk_sync}, {31'h0, ek});
      check({31'h0, bus_out.internal_ram}, {31'h0, ram});
   endtask : do_read
   task automatic do_write(input mmx_op_t op, input logic [31:0] ta, input logic [1:0] sz,
         input int n, input logic ram, input logic ek);
      mmx_cmd_t c;
      c = mk(op, sz, 32'h1122_3344);
      c.target_address = ta;
      c.src_internal_ram = ram;
      run_cmd(c);
      check(32'(aq.size()), 32'(n));
      for (int i = 0; i < n; i++) begin
         check(aq[i], ta + ((n == 4) ? 32'h6 : 32'h2) - 32'(2 * i));
         check(wq[i], (32'h1122_3344 >> (8 * i)) & 32'hFF);
         if (ek) check(eq[i], 32'h0);
         if (ram) check(rq[i], 32'(RAM_SYNC_CYCLES));
      end
      check({31'h0, bus_out.eclk_sync}, {31'h0, ek});
      check({31'h0, bus_out.internal_ram}, {31'h0, ram});
   endtask : do_write
   task automatic t_read();
      do_read(MMX_OP_PERIPHERAL_READ, 32'h100, 2'h0, 2, 1'b0, 1'b0);
      slow <= 1'b1;
      do_read(MMX_OP_PERIPHERAL_READ, 32'h201, 2'h1, 4, 1'b0, 1'b0);
      slow <= 1'b0;
      do_read(MMX_OP_PERIPHERAL_READ_ECLK, 32'h301, SZ_WORD, 2, 1'b0, 1'b1);
      do_read(MMX_OP_PERIPHERAL_READ_ECLK, 32'h400, SZ_LONG, 4, 1'b1, 1'b1);
   endtask : t_read
   task automatic t_write();
      do_write(MMX_OP_PERIPHERAL_WRITE, 32'h500, 2'h0, 2, 1'b0, 1'b0);
      slow <= 1'b1;
      do_write(MMX_OP_PERIPHERAL_WRITE, 32'h601, 2'h1, 4, 1'b0, 1'b0);
      do_write(MMX_OP_PERIPHERAL_WRITE_ECLK, 32'h701, SZ_LONG, 4, 1'b0, 1'b1);
      slow <= 1'b0;
      do_write(MMX_OP_PERIPHERAL_WRITE_ECLK, 32'h800, SZ_WORD, 2, 1'b1, 1'b1);
   endtask : t_write
   task automatic complete_run();
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : complete_run
   initial begin
      repeat (10) @(posedge clk_in);
      rst_n_in <= 1'b1;
      t_move();
      t_mul();
      t_read();
      t_write();
      complete_run();
   end
endmodule : mmx_exec_tb
`default_nettype wire
